/* include/mqfoc_pkg.sv */
// Purpose: Shared constants and types for the queue flag output control
// Assumes: One clock for read and write sides, APB register access
// Notes: Offsets are byte addresses of 32-bit words
package mqfoc_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int QUEUES = 4;
	localparam int QBITS = 2;
	localparam int DEV_BITS = 3;
	localparam int RD_ADDR_W = 6;
	localparam int WR_ADDR_W = 5;
	localparam int RD_NULL_BIT = 2;
	localparam int RD_DEV_LSB = 3;
	localparam int WR_DEV_LSB = 2;
	localparam int OV_STAGES = 2;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam int CTRL_ID_LSB = 0;
	localparam int CTRL_LAST_LSB = 4;
	localparam logic [2:0] CTRL_ID_RST = 3'h0;
	localparam logic [2:0] CTRL_LAST_RST = 3'h0;
	localparam int ST_RQ_LSB = 0;
	localparam int ST_RNULL = 2;
	localparam int ST_RSEL = 3;
	localparam int ST_WQ_LSB = 4;
	localparam int ST_WSEL = 6;
	localparam int ST_NARROW = 7;
	localparam int ST_PRIMARY = 8;
	localparam int ST_POLLED = 9;
	localparam int FL_EMPTY_LSB = 0;
	localparam int FL_FULL_LSB = 4;
	localparam int FL_NEMPTY_LSB = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {FLAG_DIRECT, FLAG_POLLED} mqfoc_scheme_e;

	typedef struct packed {
		logic narrow;
		logic primary;
		mqfoc_scheme_e scheme;
	} mqfoc_cfg_s;

	typedef struct packed {
		logic [QBITS-1:0] queue;
		logic is_null;
		logic dev_hit;
	} mqfoc_sel_s;

	localparam mqfoc_cfg_s CFG_RST = '{narrow: 1'b0, primary: 1'b0, scheme: FLAG_DIRECT};
	localparam mqfoc_sel_s SEL_RST = '{queue: '0, is_null: 1'b1, dev_hit: 1'b0};
endpackage

/* hdl/mqfoc_flag_bus.sv */
// Purpose: One four-bit flag bus in direct or polled presentation
// Assumes: Strobe and address synchronous to sys_clk
// Notes: Bus and enable are registered
module mqfoc_flag_bus #(
	parameter int WIDTH = 4,
	parameter int DEV_W = 3
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic full_reset_n,
	// Configuration
	input wire logic polled,
	input wire logic [DEV_W-1:0] own_id,
	input wire logic [DEV_W-1:0] last_id,
	// Direct selection
	input wire logic strobe,
	input wire logic [DEV_W-1:0] dev_addr,
	// Status in
	input wire logic [WIDTH-1:0] flags_n,
	// Bus out
	output logic [WIDTH-1:0] bus_q,
	output logic bus_oe_q
);
	if (WIDTH < 1 || DEV_W < 1)
	begin : g_bad_width
		$error("mqfoc_flag_bus: bad width");
	end

	logic [DEV_W-1:0] poll_idx_q;
	logic hit_q;

	// ----------------------------------------
	// Device walk, one per edge
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			poll_idx_q <= '0;
		else if (!full_reset_n || !polled || poll_idx_q == last_id)
			poll_idx_q <= '0;
		else
			poll_idx_q <= poll_idx_q + 1'b1;
	end

	// ----------------------------------------
	// Direct selection latch
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			hit_q <= 1'b0;
		else if (!full_reset_n)
			hit_q <= 1'b0;
		else if (strobe)
			hit_q <= (dev_addr == own_id);
	end

	// ----------------------------------------
	// Bus drive
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_q <= '1;
			bus_oe_q <= 1'b0;
		end
		else
		begin
			bus_q <= flags_n;
			if (!full_reset_n)
				bus_oe_q <= 1'b0;
			else if (polled)
				bus_oe_q <= (poll_idx_q == own_id);
			else if (strobe)
				bus_oe_q <= (dev_addr == own_id);
			else
				bus_oe_q <= hit_q;
		end
	end
endmodule // mqfoc_flag_bus

/* hdl/mqfoc_top.sv */
// Purpose: Output flags, bus drive and queue clear control of a four-queue FIFO
// Assumes: Read and write sides share sys_clk; queue core supplies raw flags
// Notes: Flag pins are active low; bus pins come with output enables
//
// The address map and register access over APB were chosen for this implementation.

// Operation
// - Primary device drives read data while output enable low, floats while high, unclocked.
// - Secondary floats read data until selected for reading, then output enable governs.
// - Valid flag follows a newly selected read queue two clocks after selection.
// - Valid flag goes high once the selected read queue is empty.
// - Valid flag has an enable so several devices may share it.
// - Output width latched at full reset: low gives 18 bits, high 9 bits.
// - Near-empty pin low, on read clock, while selected read queue is near empty.
// - Four-bit near-empty bus shows every queue of the shown device.
// - Direct or polled bus operation latched from scheme input at full reset.
// - Both flag buses have enables for sharing between devices.
// - Direct mode: empty strobe and read address pick the device shown.
// - Polled mode: near-empty bus steps one device per read clock edge.
// - Near-full pin low, on write clock, while selected write queue is near full.
// - Four-bit near-full bus shows every queue of the shown device.
// - Direct mode: full strobe, write address and enable pick the device shown.
// - Polled mode: near-full bus steps one device per write clock edge.
// - Queue clear resets only that queue's pointers; configuration stays.
// - Primary input high at full reset makes primary; secondaries float outputs.
// - Read queue chosen on a clock edge with read address enable high.
module mqfoc_top #(
	parameter int QUEUES = mqfoc_pkg::QUEUES
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic full_reset_n,
	// Straps
	input wire logic primary_sel,
	input wire logic rd_width_sel,
	input wire logic flag_scheme_sel,
	// Read port
	input wire logic out_en_n,
	input wire logic rd_addr_en,
	input wire logic empty_bus_strobe,
	input wire logic [mqfoc_pkg::RD_ADDR_W-1:0] rd_queue_addr,
	// Write port
	input wire logic wr_addr_en,
	input wire logic full_bus_strobe,
	input wire logic [mqfoc_pkg::WR_ADDR_W-1:0] wr_queue_addr,
	// Queue clear
	input wire logic queue_clear_n,
	// Raw queue status, active high
	input wire logic [QUEUES-1:0] q_empty,
	input wire logic [QUEUES-1:0] q_near_empty,
	input wire logic [QUEUES-1:0] q_near_full,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Data bus control
	output logic rd_data_oe,
	output logic rd_narrow,
	// Flag pins
	output logic word_valid_n,
	output logic word_valid_oe,
	output logic near_empty_n,
	output logic near_full_n,
	// Flag buses
	output logic [QUEUES-1:0] near_empty_bus,
	output logic near_empty_bus_oe,
	output logic [QUEUES-1:0] near_full_bus,
	output logic near_full_bus_oe,
	// Pointer reset to queue core
	output logic [QUEUES-1:0] queue_ptr_clear
);
	if (QUEUES != (1 << mqfoc_pkg::QBITS))
	begin : g_bad_queues
		$error("mqfoc_top: QUEUES must match queue address width");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic pick(input logic [QUEUES-1:0] v,
		input logic [mqfoc_pkg::QBITS-1:0] i);
		pick = v[i];
	endfunction

	mqfoc_pkg::mqfoc_cfg_s cfg_q;
	mqfoc_pkg::mqfoc_sel_s rsel_q;
	mqfoc_pkg::mqfoc_sel_s wsel_q;
	logic [2:0] dev_id_q;
	logic [2:0] last_id_q;
	logic any_rsel_q;
	logic ov_stage_q;
	logic word_valid_n_q;
	logic word_valid_oe_q;
	logic rd_narrow_q;
	logic near_empty_n_q;
	logic near_full_n_q;
	logic clear_seen_q;
	logic [QUEUES-1:0] ptr_clear_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic rd_hit;
	logic wr_hit;
	logic [2:0] rd_dev;
	logic [2:0] wr_dev;
	logic [QUEUES-1:0] ne_bus;
	logic ne_oe;
	logic [QUEUES-1:0] nf_bus;
	logic nf_oe;

	assign rd_dev = rd_queue_addr[mqfoc_pkg::RD_ADDR_W-1:mqfoc_pkg::RD_DEV_LSB];
	assign wr_dev = wr_queue_addr[mqfoc_pkg::WR_ADDR_W-1:mqfoc_pkg::WR_DEV_LSB];
	assign rd_hit = (rd_dev == dev_id_q);
	assign wr_hit = (wr_dev == dev_id_q);

	// ----------------------------------------
	// Strap capture during full reset
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			cfg_q <= mqfoc_pkg::CFG_RST;
		else if (!full_reset_n)
		begin
			cfg_q.narrow <= rd_width_sel;
			cfg_q.primary <= primary_sel;
			cfg_q.scheme <= flag_scheme_sel ? mqfoc_pkg::FLAG_POLLED
				: mqfoc_pkg::FLAG_DIRECT;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_narrow_q <= 1'b0;
		else
			rd_narrow_q <= cfg_q.narrow;
	end

	// ----------------------------------------
	// Read queue selection
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rsel_q <= mqfoc_pkg::SEL_RST;
			any_rsel_q <= 1'b0;
		end
		else if (!full_reset_n)
		begin
			rsel_q <= mqfoc_pkg::SEL_RST;
			any_rsel_q <= 1'b0;
		end
		else if (rd_addr_en)
		begin
			rsel_q.queue <= rd_queue_addr[mqfoc_pkg::QBITS-1:0];
			rsel_q.is_null <= rd_queue_addr[mqfoc_pkg::RD_NULL_BIT];
			rsel_q.dev_hit <= rd_hit;
			any_rsel_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Write queue selection
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			wsel_q <= mqfoc_pkg::SEL_RST;
		else if (!full_reset_n)
			wsel_q <= mqfoc_pkg::SEL_RST;
		else if (wr_addr_en)
		begin
			wsel_q.queue <= wr_queue_addr[mqfoc_pkg::QBITS-1:0];
			wsel_q.is_null <= 1'b0;
			wsel_q.dev_hit <= wr_hit;
		end
	end

	// ----------------------------------------
	// Read data bus drive, unclocked
	// ----------------------------------------
	always_comb
	begin
		if (cfg_q.primary)
			rd_data_oe = !out_en_n;
		else
			rd_data_oe = rsel_q.dev_hit && !out_en_n;
	end

	// ----------------------------------------
	// Valid flag pipeline
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ov_stage_q <= 1'b1;
			word_valid_n_q <= 1'b1;
		end
		else
		begin
			ov_stage_q <= !rsel_q.dev_hit || rsel_q.is_null
				|| pick(q_empty, rsel_q.queue);
			word_valid_n_q <= ov_stage_q;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			word_valid_oe_q <= 1'b0;
		else if (!full_reset_n)
			word_valid_oe_q <= 1'b0;
		else
			word_valid_oe_q <= rsel_q.dev_hit
				|| (cfg_q.primary && !any_rsel_q);
	end

	// ----------------------------------------
	// Selected queue flag pins
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			near_empty_n_q <= 1'b1;
		else if (rsel_q.dev_hit && !rsel_q.is_null)
			near_empty_n_q <= !pick(q_near_empty, rsel_q.queue);
		else
			near_empty_n_q <= 1'b1;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			near_full_n_q <= 1'b1;
		else if (wsel_q.dev_hit)
			near_full_n_q <= !pick(q_near_full, wsel_q.queue);
		else
			near_full_n_q <= 1'b1;
	end

	// ----------------------------------------
	// Flag buses
	// ----------------------------------------
	mqfoc_flag_bus #(
		.WIDTH(QUEUES),
		.DEV_W(mqfoc_pkg::DEV_BITS)
	) u_empty_bus (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.full_reset_n(full_reset_n),
		.polled(cfg_q.scheme == mqfoc_pkg::FLAG_POLLED),
		.own_id(dev_id_q),
		.last_id(last_id_q),
		.strobe(empty_bus_strobe),
		.dev_addr(rd_dev),
		.flags_n(~q_near_empty),
		.bus_q(ne_bus),
		.bus_oe_q(ne_oe)
	);

	mqfoc_flag_bus #(
		.WIDTH(QUEUES),
		.DEV_W(mqfoc_pkg::DEV_BITS)
	) u_full_bus (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.full_reset_n(full_reset_n),
		.polled(cfg_q.scheme == mqfoc_pkg::FLAG_POLLED),
		.own_id(dev_id_q),
		.last_id(last_id_q),
		.strobe(full_bus_strobe && wr_addr_en),
		.dev_addr(wr_dev),
		.flags_n(~q_near_full),
		.bus_q(nf_bus),
		.bus_oe_q(nf_oe)
	);

	// ----------------------------------------
	// Queue clear, one pulse per low level
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			clear_seen_q <= 1'b0;
		else
			clear_seen_q <= !queue_clear_n;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			ptr_clear_q <= '0;
		else
		begin
			ptr_clear_q <= '0;
			if (!queue_clear_n && !clear_seen_q && wsel_q.dev_hit && rsel_q.dev_hit
				&& !rsel_q.is_null && wsel_q.queue == rsel_q.queue)
				ptr_clear_q[wsel_q.queue] <= 1'b1;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dev_id_q <= mqfoc_pkg::CTRL_ID_RST;
			last_id_q <= mqfoc_pkg::CTRL_LAST_RST;
		end
		else if (psel && penable && pready_q && pwrite && paddr == mqfoc_pkg::ADDR_CTRL)
		begin
			dev_id_q <= pwdata[mqfoc_pkg::CTRL_ID_LSB +: mqfoc_pkg::DEV_BITS];
			last_id_q <= pwdata[mqfoc_pkg::CTRL_LAST_LSB +: mqfoc_pkg::DEV_BITS];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			pready_q <= 1'b0;
		else
			pready_q <= psel && penable && !pready_q;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end
		else if (psel && penable && !pready_q)
		begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
			if (paddr == mqfoc_pkg::ADDR_CTRL)
			begin
				prdata_q[mqfoc_pkg::CTRL_ID_LSB +: mqfoc_pkg::DEV_BITS] <= dev_id_q;
				prdata_q[mqfoc_pkg::CTRL_LAST_LSB +: mqfoc_pkg::DEV_BITS] <= last_id_q;
			end
			else if (paddr == mqfoc_pkg::ADDR_STATUS)
			begin
				prdata_q[mqfoc_pkg::ST_RQ_LSB +: mqfoc_pkg::QBITS] <= rsel_q.queue;
				prdata_q[mqfoc_pkg::ST_RNULL] <= rsel_q.is_null;
				prdata_q[mqfoc_pkg::ST_RSEL] <= rsel_q.dev_hit;
				prdata_q[mqfoc_pkg::ST_WQ_LSB +: mqfoc_pkg::QBITS] <= wsel_q.queue;
				prdata_q[mqfoc_pkg::ST_WSEL] <= wsel_q.dev_hit;
				prdata_q[mqfoc_pkg::ST_NARROW] <= cfg_q.narrow;
				prdata_q[mqfoc_pkg::ST_PRIMARY] <= cfg_q.primary;
				prdata_q[mqfoc_pkg::ST_POLLED] <= (cfg_q.scheme == mqfoc_pkg::FLAG_POLLED);
			end
			else if (paddr == mqfoc_pkg::ADDR_FLAGS)
			begin
				prdata_q[mqfoc_pkg::FL_EMPTY_LSB +: QUEUES] <= q_empty;
				prdata_q[mqfoc_pkg::FL_FULL_LSB +: QUEUES] <= q_near_full;
				prdata_q[mqfoc_pkg::FL_NEMPTY_LSB +: QUEUES] <= q_near_empty;
			end
			else
				pslverr_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rd_narrow = rd_narrow_q;
	assign word_valid_n = word_valid_n_q;
	assign word_valid_oe = word_valid_oe_q;
	assign near_empty_n = near_empty_n_q;
	assign near_full_n = near_full_n_q;
	assign near_empty_bus = ne_bus;
	assign near_empty_bus_oe = ne_oe;
	assign near_full_bus = nf_bus;
	assign near_full_bus_oe = nf_oe;
	assign queue_ptr_clear = ptr_clear_q;
endmodule // mqfoc_top

/* testbench/mqfoc_asserts.sv */
// Purpose: Port checks of the queue flag output control
// Assumes: Device id follows CTRL writes
// Notes: Bound from the bench top file
module mqfoc_asserts #(
	parameter int QUEUES = mqfoc_pkg::QUEUES
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic full_reset_n,
	// Straps and read port
	input wire logic primary_sel,
	input wire logic rd_width_sel,
	input wire logic flag_scheme_sel,
	input wire logic out_en_n,
	input wire logic empty_bus_strobe,
	input wire logic [mqfoc_pkg::RD_ADDR_W-1:0] rd_queue_addr,
	// Write port and clear
	input wire logic wr_addr_en,
	input wire logic full_bus_strobe,
	input wire logic [mqfoc_pkg::WR_ADDR_W-1:0] wr_queue_addr,
	input wire logic queue_clear_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Outputs
	input wire logic rd_data_oe,
	input wire logic rd_narrow,
	input wire logic near_empty_bus_oe,
	input wire logic near_full_bus_oe,
	input wire logic [QUEUES-1:0] queue_ptr_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] id_q;
	logic prim_q;
	logic poll_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prim_q <= 1'b0;
			poll_q <= 1'b0;
		end
		else if (!full_reset_n)
		begin
			prim_q <= primary_sel;
			poll_q <= flag_scheme_sel;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			id_q <= 3'h0;
		else if (psel && penable && pready && pwrite && paddr == mqfoc_pkg::ADDR_CTRL)
			id_q <= pwdata[2:0];
	end

	sequence s_empty_bus_strobe;
		full_reset_n && !poll_q && empty_bus_strobe;
	endsequence
	sequence s_full_bus_strobe;
		full_reset_n && !poll_q && full_bus_strobe && wr_addr_en;
	endsequence
	sequence s_clr_seen;
		!$past(queue_clear_n) || !$past(queue_clear_n, 2);
	endsequence

	a_oe_needs_en: assert property (rd_data_oe |-> !out_en_n)
		else $error("data enable without output enable");
	a_primary_drives: assert property (full_reset_n && prim_q && !out_en_n |-> rd_data_oe)
		else $error("primary not driving data");
	a_width_latch: assert property (!full_reset_n |-> ##2 rd_narrow == $past(rd_width_sel, 2))
		else $error("width not latched");
	a_empty_bus_sel: assert property (s_empty_bus_strobe |=>
		near_empty_bus_oe == ($past(rd_queue_addr[5:3]) == $past(id_q)))
		else $error("near empty bus selection wrong");
	a_full_bus_sel: assert property (s_full_bus_strobe |=>
		near_full_bus_oe == ($past(wr_queue_addr[4:2]) == $past(id_q)))
		else $error("near full bus selection wrong");
	a_clear_single: assert property (queue_ptr_clear != '0 |=> queue_ptr_clear == '0)
		else $error("clear pulse too long");
	a_clear_onehot: assert property ($onehot0(queue_ptr_clear))
		else $error("clear hits several queues");
	a_clear_cause: assert property (queue_ptr_clear != '0 |-> s_clr_seen)
		else $error("clear without request");
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
endmodule // mqfoc_asserts

/* testbench/mqfoc_ctl_model.sv */
// Purpose: Read and write controller model driving queue selection
// Assumes: One command at a time, go high for one cycle
// Notes: Idle address lines toggle so stale values never look valid
module mqfoc_ctl_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Command: 1 select, 2 select then clear, 3 bus strobe
	input wire logic go,
	input wire logic [1:0] kind,
	input wire logic [5:0] addr,
	// Read side
	output logic rd_addr_en,
	output logic empty_bus_strobe,
	output logic [mqfoc_pkg::RD_ADDR_W-1:0] rd_queue_addr,
	// Write side and clear
	output logic wr_addr_en,
	output logic full_bus_strobe,
	output logic [mqfoc_pkg::WR_ADDR_W-1:0] wr_queue_addr,
	output logic queue_clear_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] step_q;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			step_q <= 2'h0;
			rd_addr_en <= 1'b0;
			wr_addr_en <= 1'b0;
			empty_bus_strobe <= 1'b0;
			full_bus_strobe <= 1'b0;
			rd_queue_addr <= 6'h00;
			wr_queue_addr <= 5'h00;
			queue_clear_n <= 1'b1;
		end
		else
		begin
			rd_addr_en <= go && kind != 2'h3;
			wr_addr_en <= go;
			empty_bus_strobe <= go && kind == 2'h3;
			full_bus_strobe <= go && kind == 2'h3;
			rd_queue_addr <= go ? addr : ~rd_queue_addr;
			wr_queue_addr <= go ? {addr[5:3], addr[1:0]} : ~wr_queue_addr;
			queue_clear_n <= step_q != 2'h1;
			if (go && kind == 2'h2)
				step_q <= 2'h3;
			else if (step_q != 2'h0)
				step_q <= step_q - 2'h1;
		end
	end
endmodule // mqfoc_ctl_model

/* testbench/mqfoc_top_tb.sv */
// Purpose: Self-checking bench of the queue flag output control
// Assumes: Controller model drives selection, bench drives APB
// Notes: Tests are sequences of bus and command calls
module mqfoc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic full_reset_n = 1'b0;
	logic primary_sel = 1'b0;
	logic rd_width_sel = 1'b0;
	logic flag_scheme_sel = 1'b0;
	logic out_en_n = 1'b1;
	logic [3:0] q_empty = 4'h0;
	logic [3:0] q_near_empty = 4'h4;
	logic [3:0] q_near_full = 4'h4;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic go = 1'b0;
	logic [1:0] kind = 2'h0;
	logic [5:0] caddr = 6'h00;
	logic rd_addr_en, empty_bus_strobe, wr_addr_en, full_bus_strobe, queue_clear_n;
	logic [5:0] rd_queue_addr;
	logic [4:0] wr_queue_addr;
	logic [31:0] prdata, d;
	logic pready, pslverr, rd_data_oe, rd_narrow, word_valid_n, word_valid_oe, e;
	logic near_empty_n, near_full_n, near_empty_bus_oe, near_full_bus_oe;
	logic [3:0] near_empty_bus, near_full_bus, queue_ptr_clear, v;
	int err_count = 0;
	int checked = 0;
	int n, ne, nf;

	mqfoc_top i_mqfoc_top (.sys_clk, .arst_n, .full_reset_n, .primary_sel, .rd_width_sel,
		.flag_scheme_sel, .out_en_n, .rd_addr_en, .empty_bus_strobe, .rd_queue_addr,
		.wr_addr_en, .full_bus_strobe, .wr_queue_addr, .queue_clear_n, .q_empty,
		.q_near_empty, .q_near_full, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rd_data_oe, .rd_narrow, .word_valid_n, .word_valid_oe,
		.near_empty_n, .near_full_n, .near_empty_bus, .near_empty_bus_oe, .near_full_bus,
		.near_full_bus_oe, .queue_ptr_clear);
	mqfoc_ctl_model i_mqfoc_ctl_model (.sys_clk, .arst_n, .go, .kind, .addr(caddr),
		.rd_addr_en, .empty_bus_strobe, .rd_queue_addr, .wr_addr_en, .full_bus_strobe,
		.wr_queue_addr, .queue_clear_n);

	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			err_count++;
			$display("BAD %0t seen %h exp %h", $time, s, x);
		end
	endtask

	task automatic w(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [1:0] k, input logic [5:0] a);
		@(posedge sys_clk);
		go <= 1'b1;
		kind <= k;
		caddr <= a;
		@(posedge sys_clk);
		go <= 1'b0;
	endtask

	task automatic freset(input logic p, input logic nw, input logic m);
		@(posedge sys_clk);
		full_reset_n <= 1'b0;
		primary_sel <= p;
		rd_width_sel <= nw;
		flag_scheme_sel <= m;
		repeat (2) @(posedge sys_clk);
		full_reset_n <= 1'b1;
		primary_sel <= ~p;
		rd_width_sel <= ~nw;
		flag_scheme_sel <= ~m;
		w(3);
	endtask

	task automatic end_sim;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#40000;
		err_count++;
		end_sim();
	end

	initial
	begin
		w(2);
		chk({rd_data_oe, word_valid_oe, near_empty_bus_oe, near_full_bus_oe}, 4'h0);
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		freset(1'b1, 1'b1, 1'b0);
		chk(rd_narrow, 1'b1);
		@(posedge sys_clk);
		out_en_n <= 1'b0;
		#1;
		chk(rd_data_oe, 1'b1);
		@(posedge sys_clk);
		out_en_n <= 1'b1;
		#1;
		chk(rd_data_oe, 1'b0);
		apb(1'b0, mqfoc_pkg::ADDR_STATUS, 32'h0);
		chk(d & 32'h380, 32'h180);
		apb(1'b0, 8'h0C, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(d, 32'h0);
		apb(1'b1, mqfoc_pkg::ADDR_CTRL, 32'h10);
		apb(1'b0, mqfoc_pkg::ADDR_CTRL, 32'h0);
		chk(d, 32'h10);
		$display("test straps done");
		cmd(2'h1, 6'h02);
		w(2);
		chk(word_valid_n, 1'b1);
		w(1);
		chk({word_valid_n, near_empty_n, near_full_n}, 3'h0);
		chk(word_valid_oe, 1'b1);
		@(posedge sys_clk);
		q_empty <= 4'h4;
		w(4);
		chk(word_valid_n, 1'b1);
		$display("test read select done");
		cmd(2'h3, 6'h00);
		w(3);
		chk({near_empty_bus_oe, near_empty_bus}, 5'h1B);
		chk({near_full_bus_oe, near_full_bus}, 5'h1B);
		cmd(2'h3, 6'h08);
		w(3);
		chk({near_empty_bus_oe, near_full_bus_oe}, 2'h0);
		$display("test direct buses done");
		cmd(2'h2, 6'h01);
		v = 4'h0;
		n = 0;
		repeat (10)
		begin
			w(1);
			if (queue_ptr_clear !== 4'h0)
			begin
				v = queue_ptr_clear;
				n++;
			end
		end
		chk(v, 4'h2);
		chk(n, 1);
		apb(1'b0, mqfoc_pkg::ADDR_STATUS, 32'h0);
		chk(d & 32'h380, 32'h180);
		$display("test queue clear done");
		freset(1'b0, 1'b0, 1'b0);
		@(posedge sys_clk);
		out_en_n <= 1'b0;
		w(1);
		chk({rd_data_oe, rd_narrow, word_valid_oe}, 3'h0);
		cmd(2'h1, 6'h03);
		w(3);
		chk(rd_data_oe, 1'b1);
		$display("test secondary done");
		freset(1'b1, 1'b0, 1'b1);
		ne = 0;
		nf = 0;
		repeat (8)
		begin
			w(1);
			ne += near_empty_bus_oe;
			nf += near_full_bus_oe;
		end
		chk(ne, 4);
		chk(nf, 4);
		$display("test polled done");
		end_sim();
	end
endmodule // mqfoc_top_tb

bind mqfoc_top mqfoc_asserts #(.QUEUES(QUEUES)) i_mqfoc_asserts (.sys_clk, .arst_n,
	.full_reset_n, .primary_sel, .rd_width_sel, .flag_scheme_sel, .out_en_n,
	.empty_bus_strobe, .rd_queue_addr, .wr_addr_en, .full_bus_strobe, .wr_queue_addr,
	.queue_clear_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .rd_data_oe,
	.rd_narrow, .near_empty_bus_oe, .near_full_bus_oe, .queue_ptr_clear);
